// ---- core/bcp_framer.v ----
/*
  Boot command packet framer: receives framed command and data packets
  byte by byte, checks the checksum and layout, decodes the command tag,
  and sends framed reply packets built from registers.
  Assumes a byte stream with valid/ready on each side, an Avalon-MM
  master for registers, and a sideband enable pin from another domain.
*/
`timescale 1ns/1ps
`include "bcp_defines.vh"

module bcp_framer (
  input  wire        clk_sys,
  input  wire        nrst,
  // Avalon-MM slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // Receive byte stream
  input  wire [7:0]  rx_data,
  input  wire        rx_valid,
  output wire        rx_ready,
  // Transmit byte stream
  output reg  [7:0]  tx_data,
  output wire        tx_valid,
  input  wire        tx_ready,
  // Asynchronous enable pin from board
  input  wire        link_enable_pin,
  // Packet events
  output reg         cmd_accept,
  output reg         cmd_error,
  output reg  [7:0]  cmd_tag,
  output reg         cmd_data_phase,
  output reg  [7:0]  cmd_argument_tally
);

  //////////////////////////////////////////////////////////////////////
  // Receive state codes
  localparam RX_START = 3'd0;
  localparam RX_TYPE  = 3'd1;
  localparam RX_LEN0  = 3'd2;
  localparam RX_LEN1  = 3'd3;
  localparam RX_CRC0  = 3'd4;
  localparam RX_CRC1  = 3'd5;
  localparam RX_BODY  = 3'd6;
  localparam RX_DONE  = 3'd7;

  // Transmit state codes
  localparam TX_IDLE  = 2'd0;
  localparam TX_CALC  = 2'd1;
  localparam TX_SEND  = 2'd2;

  //////////////////////////////////////////////////////////////////////
  // Declarations
  reg  [7:0]  ctrl_reg;
  reg  [2:0]  rx_state_reg;
  reg  [7:0]  rx_type_reg;
  reg  [15:0] rx_len_reg;
  reg  [15:0] rx_cnt_reg;
  reg  [15:0] rx_crc_reg;
  reg  [15:0] rx_sum_reg;
  reg  [7:0]  rx_buf [0:31];
  reg  [7:0]  tx_buf [0:31];
  reg  [7:0]  tx_hdr [0:5];
  reg  [15:0] tx_sum_reg;
  reg  [15:0] tx_len_reg;
  reg  [15:0] tx_cnt_reg;
  reg  [1:0]  tx_state_reg;
  reg  [2:0]  arg_sel_reg;
  reg         crc_err_reg;
  reg         cnt_err_reg;
  reg         tag_err_reg;
  reg         pay_seen_reg;
  reg  [15:0] test_sum_reg;
  reg  [7:0]  rx_tag;
  reg         tag_ok;
  wire [15:0] rx_sum_next;
  wire [15:0] tx_sum_next;
  wire [15:0] test_sum_next;
  wire        link_en;
  wire        rx_take;
  wire        tx_take;
  wire [7:0]  tx_calc_byte;
  wire [4:0]  rx_idx;
  wire [4:0]  tx_idx;
  wire [4:0]  arg_base;
  integer     k;
  integer     m;
  integer     n;

  //////////////////////////////////////////////////////////////////////
  // Sideband enable pin crossing
  bcp_sync3 u_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .din     (link_enable_pin),
    .dout    (link_en)
  );

  // Receive and transmit checksum steps, plus a software test engine
  bcp_crc16 u_rx_crc (
    .crc_in  (rx_sum_reg),
    .data_in (rx_data),
    .crc_out (rx_sum_next)
  );

  bcp_crc16 u_tx_crc (
    .crc_in  (tx_sum_reg),
    .data_in (tx_calc_byte),
    .crc_out (tx_sum_next)
  );

  bcp_crc16 u_test_crc (
    .crc_in  (test_sum_reg),
    .data_in (avs_writedata[7:0]),
    .crc_out (test_sum_next)
  );

  //////////////////////////////////////////////////////////////////////
  // Handshakes; bus answers in the cycle of the request
  assign avs_waitrequest = 1'b0;
  assign rx_ready = ctrl_reg[`BCP_CTRL_RX_EN] & link_en & (rx_state_reg != RX_DONE);
  assign rx_take  = rx_valid & rx_ready;
  assign tx_valid = (tx_state_reg == TX_SEND);
  assign tx_take  = tx_valid & tx_ready;
  assign rx_idx   = rx_cnt_reg[4:0];
  assign tx_idx   = tx_cnt_reg[4:0];
  assign arg_base = {arg_sel_reg, 2'b00} + 5'd4;
  // Checksum pass walks start, type and length, then payload
  assign tx_calc_byte = (tx_cnt_reg < 16'd4) ? tx_hdr[tx_cnt_reg[2:0]]
                                             : tx_buf[tx_cnt_reg[4:0] - 5'd4];

  // Command tag decode, 0x11 valid only when software enables it
  always @* begin
    rx_tag = rx_buf[0];
    tag_ok = 1'b0;
    if (rx_tag >= `BCP_OP_ERASE_ALL && rx_tag <= `BCP_OP_LAST_LOW &&
        rx_tag != `BCP_OP_RESERVED_A) begin
      tag_ok = 1'b1;
    end else if (rx_tag == `BCP_OP_RESOURCE || rx_tag == `BCP_OP_SAFE_UPGRADE) begin
      tag_ok = 1'b1;
    end else if (rx_tag == `BCP_OP_QSPI_SETUP) begin
      tag_ok = ctrl_reg[`BCP_CTRL_QSPI_OK];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Receive framing state machine
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rx_state_reg   <= RX_START;
      rx_type_reg    <= 8'h00;
      rx_len_reg     <= 16'h0000;
      rx_cnt_reg     <= 16'h0000;
      rx_crc_reg     <= 16'h0000;
      rx_sum_reg     <= `BCP_CRC_INIT;
      cmd_accept     <= 1'b0;
      cmd_error      <= 1'b0;
      cmd_tag        <= 8'h00;
      cmd_data_phase <= 1'b0;
      cmd_argument_tally <= 8'h00;
      crc_err_reg    <= 1'b0;
      cnt_err_reg    <= 1'b0;
      tag_err_reg    <= 1'b0;
      pay_seen_reg   <= 1'b0;
      for (k = 0; k < 32; k = k + 1) begin
        rx_buf[k] <= 8'h00;
      end
    end else begin
      cmd_accept <= 1'b0;
      cmd_error  <= 1'b0;
      // Software clears sticky errors; a new error in same cycle wins
      if (avs_write && avs_address == `BCP_REG_STATUS) begin
        crc_err_reg  <= crc_err_reg & ~avs_writedata[0];
        cnt_err_reg  <= cnt_err_reg & ~avs_writedata[1];
        tag_err_reg  <= tag_err_reg & ~avs_writedata[2];
        pay_seen_reg <= pay_seen_reg & ~avs_writedata[3];
      end
      case (rx_state_reg)
        RX_START: begin
          if (rx_take && rx_data == `BCP_START_BYTE) begin
            rx_sum_reg   <= rx_sum_next;
            rx_state_reg <= RX_TYPE;
          end
        end
        RX_TYPE: begin
          if (rx_take) begin
            rx_type_reg <= rx_data;
            rx_sum_reg  <= rx_sum_next;
            if (rx_data == `BCP_FRAME_KIND_CMD || rx_data == `BCP_FRAME_KIND_PAY) begin
              rx_state_reg <= RX_LEN0;
            end else begin
              rx_sum_reg   <= `BCP_CRC_INIT;
              rx_state_reg <= RX_START;
            end
          end
        end
        RX_LEN0: begin
          if (rx_take) begin
            rx_len_reg[7:0] <= rx_data;
            rx_sum_reg      <= rx_sum_next;
            rx_state_reg    <= RX_LEN1;
          end
        end
        RX_LEN1: begin
          if (rx_take) begin
            rx_len_reg[15:8] <= rx_data;
            rx_sum_reg       <= rx_sum_next;
            rx_state_reg     <= RX_CRC0;
          end
        end
        RX_CRC0: begin
          if (rx_take) begin
            rx_crc_reg[7:0] <= rx_data;
            rx_state_reg    <= RX_CRC1;
          end
        end
        RX_CRC1: begin
          if (rx_take) begin
            rx_crc_reg[15:8] <= rx_data;
            rx_cnt_reg       <= 16'h0000;
            rx_state_reg     <= (rx_len_reg == 16'h0000) ? RX_DONE : RX_BODY;
          end
        end
        RX_BODY: begin
          if (rx_take) begin
            if (rx_cnt_reg < 16'd32) begin
              rx_buf[rx_idx] <= rx_data;
            end
            rx_sum_reg <= rx_sum_next;
            rx_cnt_reg <= rx_cnt_reg + 16'd1;
            if (rx_cnt_reg + 16'd1 == rx_len_reg) begin
              rx_state_reg <= RX_DONE;
            end
          end
        end
        RX_DONE: begin
          rx_state_reg <= RX_START;
          rx_sum_reg   <= `BCP_CRC_INIT;
          if (rx_sum_reg != rx_crc_reg) begin
            crc_err_reg <= 1'b1;
            cmd_error   <= 1'b1;
          end else if (rx_type_reg == `BCP_FRAME_KIND_PAY) begin
            pay_seen_reg <= 1'b1;
          end else if (rx_buf[3] > `BCP_MAX_ARGS ||
                       rx_len_reg != {6'h00, rx_buf[3], 2'b00} + 16'd4) begin
            cnt_err_reg <= 1'b1;
            cmd_error   <= 1'b1;
          end else if (!tag_ok) begin
            tag_err_reg <= 1'b1;
            cmd_error   <= 1'b1;
          end else begin
            cmd_accept         <= 1'b1;
            cmd_tag            <= rx_buf[0];
            cmd_data_phase     <= rx_buf[1][`BCP_FLAG_DATA_BIT];
            cmd_argument_tally <= rx_buf[3];
          end
        end
        default: rx_state_reg <= RX_START;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Control, reply buffer and checksum test registers
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg     <= `BCP_CTRL_RST;
      arg_sel_reg  <= 3'd0;
      test_sum_reg <= `BCP_CRC_INIT;
      for (m = 0; m < 32; m = m + 1) begin
        tx_buf[m] <= 8'h00;
      end
    end else if (avs_write) begin
      case (avs_address)
        `BCP_REG_CTRL: begin
          ctrl_reg    <= avs_writedata[7:0];
          arg_sel_reg <= avs_writedata[10:8];
        end
        `BCP_REG_TX_HDR: begin
          if (tx_state_reg == TX_IDLE) begin
            // Reply header reuses the command layout
            tx_buf[0] <= avs_writedata[7:0];
            tx_buf[1] <= avs_writedata[15:8];
            tx_buf[2] <= 8'h00;
            tx_buf[3] <= (avs_writedata[31:24] > `BCP_MAX_ARGS) ?
                         `BCP_MAX_ARGS : avs_writedata[31:24];
          end
        end
        `BCP_REG_TX_ARG: begin
          if (tx_state_reg == TX_IDLE) begin
            tx_buf[arg_base]        <= avs_writedata[7:0];
            tx_buf[arg_base + 5'd1] <= avs_writedata[15:8];
            tx_buf[arg_base + 5'd2] <= avs_writedata[23:16];
            tx_buf[arg_base + 5'd3] <= avs_writedata[31:24];
          end
        end
        `BCP_REG_CRC_TEST: begin
          // Bit 8 restarts the engine, else the low byte is folded in
          test_sum_reg <= avs_writedata[8] ? `BCP_CRC_INIT : test_sum_next;
        end
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Transmit: checksum pass over header and payload, then send bytes
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tx_state_reg <= TX_IDLE;
      tx_sum_reg   <= `BCP_CRC_INIT;
      tx_len_reg   <= 16'h0000;
      tx_cnt_reg   <= 16'h0000;
      for (n = 0; n < 6; n = n + 1) begin
        tx_hdr[n] <= 8'h00;
      end
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          if (avs_write && avs_address == `BCP_REG_TX_GO) begin
            tx_len_reg   <= {6'h00, tx_buf[3], 2'b00} + 16'd4;
            tx_hdr[0]    <= `BCP_START_BYTE;
            tx_hdr[1]    <= `BCP_FRAME_KIND_CMD;
            tx_hdr[2]    <= {tx_buf[3][5:0], 2'b00} + 8'd4;
            tx_hdr[3]    <= 8'h00;
            tx_sum_reg   <= `BCP_CRC_INIT;
            tx_cnt_reg   <= 16'd0;
            tx_state_reg <= TX_CALC;
          end
        end
        TX_CALC: begin
          // Four header bytes first, checksum bytes skipped, then payload
          tx_sum_reg <= tx_sum_next;
          tx_cnt_reg <= tx_cnt_reg + 16'd1;
          if (tx_cnt_reg == tx_len_reg + 16'd3) begin
            tx_hdr[4]    <= tx_sum_next[7:0];
            tx_hdr[5]    <= tx_sum_next[15:8];
            tx_cnt_reg   <= 16'h0000;
            tx_state_reg <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (tx_take) begin
            tx_cnt_reg <= tx_cnt_reg + 16'd1;
            if (tx_cnt_reg == tx_len_reg + 16'd5) begin
              tx_state_reg <= TX_IDLE;
            end
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // Output byte register tracks the position being offered
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tx_data <= 8'h00;
    end else if (tx_state_reg == TX_CALC) begin
      tx_data <= `BCP_START_BYTE;
    end else if (tx_take) begin
      tx_data <= (tx_cnt_reg < 16'd5) ? tx_hdr[tx_cnt_reg[2:0] + 3'd1]
                                      : tx_buf[tx_idx - 5'd5];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Register read mux, registered one cycle behind is avoided
  always @* begin
    case (avs_address)
      `BCP_REG_CTRL:     avs_readdata = {21'h000000, arg_sel_reg, ctrl_reg};
      `BCP_REG_STATUS:   avs_readdata = {24'h000000, tx_state_reg != TX_IDLE,
                                         rx_state_reg, pay_seen_reg, tag_err_reg,
                                         cnt_err_reg, crc_err_reg};
      `BCP_REG_RX_HDR:   avs_readdata = {rx_buf[3], rx_buf[2], rx_buf[1], rx_buf[0]};
      `BCP_REG_RX_ARG:   avs_readdata = {rx_buf[arg_base + 5'd3], rx_buf[arg_base + 5'd2],
                                         rx_buf[arg_base + 5'd1], rx_buf[arg_base]};
      `BCP_REG_TX_HDR:   avs_readdata = {tx_buf[3], tx_buf[2], tx_buf[1], tx_buf[0]};
      `BCP_REG_CRC_TEST: avs_readdata = {16'h0000, test_sum_reg};
      default:           avs_readdata = 32'h00000000;
    endcase
  end

endmodule

// ---- core/bcp_defines.vh ----
/*
  Constants for the boot command packet framer: framing bytes, packet
  layout, command and reply tags, checksum figures, register map.
  Assumes inclusion by bare name from the core design files.
*/
// Function
// - Checksum covers header minus checksum, then payload
// - Sixteen-bit checksum, generator 0x1021
// - Start zero, no reflection, no final xor
// - Digits one to nine give 0x31C3
// - Xor byte high, eight shift steps
// - Command packet: header word, parameter words
// - Header bytes: tag, flags, reserved, count
// - Exactly count parameters, at most seven
// - Replies reuse command layout inside frames
// - Decode command tags, 0x08 reserved
// - Reply tags answer only their command
// - Flags bit 0 announces data phase
// - Data length comes from parameter word
// - Multi-byte fields least significant byte first
// - Frame: start, type, length, checksum, payload
// - Type 0xA4 command, 0xA5 data
`ifndef BCP_DEFINES_VH
`define BCP_DEFINES_VH

// Framing
`define BCP_START_BYTE     8'h5A
`define BCP_FRAME_KIND_CMD 8'hA4
`define BCP_FRAME_KIND_PAY 8'hA5
`define BCP_MAX_ARGS       8'h07
`define BCP_FLAG_DATA_BIT  0

// Checksum
`define BCP_CRC_POLY       16'h1021
`define BCP_CRC_INIT       16'h0000
`define BCP_CRC_CHECK      16'h31C3

// Command tags
`define BCP_OP_ERASE_ALL    8'h01
`define BCP_OP_RESERVED_A   8'h08
`define BCP_OP_LAST_LOW     8'h0F
`define BCP_OP_RESOURCE     8'h10
`define BCP_OP_QSPI_SETUP   8'h11
`define BCP_OP_SAFE_UPGRADE 8'h12
`define BCP_OP_FETCH_MEM    8'h03
`define BCP_OP_QUERY_SET    8'h07
`define BCP_OP_OTP_FETCH    8'h0F

// Reply tags
`define BCP_RT_PLAIN        8'hA0
`define BCP_RT_SETTING      8'hA7
`define BCP_RT_MEM_FETCH    8'hA3
`define BCP_RT_OTP_FETCH    8'hAF
`define BCP_RT_RESOURCE     8'hB0

// Register word addresses
`define BCP_REG_CTRL        4'h0
`define BCP_REG_STATUS      4'h1
`define BCP_REG_RX_HDR      4'h2
`define BCP_REG_RX_ARG      4'h3
`define BCP_REG_TX_HDR      4'h4
`define BCP_REG_TX_ARG      4'h5
`define BCP_REG_TX_GO       4'h6
`define BCP_REG_CRC_TEST    4'h7
`define BCP_ARG_SEL_W       3

// Control bits
`define BCP_CTRL_RX_EN      0
`define BCP_CTRL_QSPI_OK    1
`define BCP_CTRL_RST        8'h01

`endif

// ---- core/bcp_crc16.v ----
/*
  Byte-wide checksum step: one byte folded into a 16-bit running value
  in a single cycle.
  Assumes the caller holds the running value and seeds it per packet.
*/
`timescale 1ns/1ps
`include "bcp_defines.vh"

module bcp_crc16 (
  input  wire [15:0] crc_in,
  input  wire [7:0]  data_in,
  output reg  [15:0] crc_out
);

  integer i;

  // Xor byte into high half, then eight shift steps
  always @* begin
    crc_out = crc_in ^ {data_in, 8'h00};
    for (i = 0; i < 8; i = i + 1) begin
      if (crc_out[15]) begin
        crc_out = {crc_out[14:0], 1'b0} ^ `BCP_CRC_POLY;
      end else begin
        crc_out = {crc_out[14:0], 1'b0};
      end
    end
  end

endmodule

// ---- core/bcp_sync3.v ----
/*
  Three flip-flop input synchroniser; a change counts once the second
  and third stages agree.
  Assumes an asynchronous source and one system clock.
*/
`timescale 1ns/1ps

module bcp_sync3 (
  input  wire clk_sys,
  input  wire nrst,
  input  wire din,
  output reg  dout
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // Shift chain, output follows when stages two and three agree
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      dout   <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        dout <= s3_reg;
      end
    end
  end

endmodule

// ---- testbench/bcp_framer_checker.sv ----
/*
  Port checker for the boot command packet framer.
  Assumes one clock domain and binding onto bcp_framer.
*/
`timescale 1ns/1ps
module bcp_framer_checker (
  input wire       clk_sys,
  input wire       nrst,
  input wire       cmd_accept,
  input wire       cmd_error,
  input wire [7:0] cmd_tag,
  input wire [7:0] cmd_argument_tally,
  input wire [7:0] tx_data,
  input wire       tx_valid,
  input wire       tx_ready
);
  reg [5:0] tx_idx_reg;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // Counts bytes taken within the outgoing frame
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst)
      tx_idx_reg <= 6'h00;
    else if (!tx_valid)
      tx_idx_reg <= 6'h00;
    else if (tx_ready)
      tx_idx_reg <= tx_idx_reg + 6'h01;
  end

  ////////////////////////////////////////////////////////////
  one_verdict_a: assert property (!(cmd_accept && cmd_error))
    else $error("accept and error together");
  verdict_pulse_a: assert property ((cmd_accept || cmd_error) |=> !cmd_accept && !cmd_error)
    else $error("verdict longer than one cycle");
  tally_max_a: assert property (cmd_argument_tally <= 8'h07)
    else $error("argument tally above seven");
  tag_listed_a: assert property (cmd_accept |=> cmd_tag >= 8'h01 && cmd_tag <= 8'h12 && cmd_tag != 8'h08)
    else $error("unlisted tag accepted");
  frame_start_a: assert property (tx_valid && tx_idx_reg == 6'h00 |-> tx_data == 8'h5A)
    else $error("reply does not open with start byte");
  frame_kind_a: assert property (tx_valid && tx_idx_reg == 6'h01 |-> tx_data == 8'hA4)
    else $error("reply frame kind wrong");
  len_high_a: assert property (tx_valid && tx_idx_reg == 6'h03 |-> tx_data == 8'h00)
    else $error("reply length high byte not zero");
  reserved_zero_a: assert property (tx_valid && tx_idx_reg == 6'h08 |-> tx_data == 8'h00)
    else $error("reply reserved byte not zero");
  tally_out_a: assert property (tx_valid && tx_idx_reg == 6'h09 |-> tx_data <= 8'h07)
    else $error("reply count above seven");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte changed while stalled");

  cover property (cmd_accept);
  cover property (cmd_error);
  cover property (tx_valid && !tx_ready);
  cover property (tx_valid && tx_ready && tx_idx_reg == 6'h09);
endmodule

bind bcp_framer bcp_framer_checker u_chk (
  .clk_sys            (clk_sys),
  .nrst               (nrst),
  .cmd_accept         (cmd_accept),
  .cmd_error          (cmd_error),
  .cmd_tag            (cmd_tag),
  .cmd_argument_tally (cmd_argument_tally),
  .tx_data            (tx_data),
  .tx_valid           (tx_valid),
  .tx_ready           (tx_ready)
);

// ---- testbench/bcp_host_model.sv ----
/*
  Host side of the byte streams: offers queued bytes, collects replies.
  Assumes the bench fills send_q and reads got_q hierarchically.
*/
`timescale 1ns/1ps
module bcp_host_model (
  input  wire       clk_sys,
  output reg  [7:0] rx_data,
  output reg        rx_valid,
  input  wire       rx_ready,
  input  wire [7:0] tx_data,
  input  wire       tx_valid,
  output reg        tx_ready,
  input  wire       slow
);
  logic [7:0] send_q[$];
  logic [7:0] got_q[$];
  logic [1:0] phase;

  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
    phase = 2'h0;
  end

  // Holds each byte until taken; idle line toggles so no stale value shows
  always @(posedge clk_sys) begin
    if (rx_valid && rx_ready)
      void'(send_q.pop_front());
    if (send_q.size() > 0) begin
      rx_valid <= 1'b1;
      rx_data <= send_q[0];
    end else begin
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
    end
  end

  // Collects reply bytes in arrival order, stalling three of four cycles when slow
  always @(posedge clk_sys) begin
    if (tx_valid && tx_ready)
      got_q.push_back(tx_data);
    phase <= phase + 2'h1;
    tx_ready <= !slow || (phase == 2'h3);
  end
endmodule

// ---- testbench/tb_top.sv ----
/*
  Self-checking bench for the boot command packet framer.
  Assumes the host model on the byte streams and the bound checker.
*/
`timescale 1ns/1ps
module tb_top;
  reg         clk_sys, nrst, avs_read, avs_write, link_enable_pin, slow;
  reg  [3:0]  avs_address;
  reg  [31:0] avs_writedata, rd;
  wire [31:0] avs_readdata;
  wire [7:0]  rx_data, tx_data, cmd_tag, cmd_argument_tally;
  wire        avs_waitrequest, rx_valid, rx_ready, tx_valid, tx_ready;
  wire        cmd_accept, cmd_error, cmd_data_phase;
  integer     bad_count, checks_done, cyc, acc_n, err_n, r;
  logic [7:0] p[$];
  logic [7:0] fr[$];

  bcp_framer u_dut (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .link_enable_pin(link_enable_pin), .cmd_accept(cmd_accept),
    .cmd_error(cmd_error), .cmd_tag(cmd_tag), .cmd_data_phase(cmd_data_phase),
    .cmd_argument_tally(cmd_argument_tally));
  bcp_host_model u_host (.clk_sys(clk_sys), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .slow(slow));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Counts verdict pulses and cuts a hang short
  always @(posedge clk_sys) begin
    if (cmd_accept === 1'b1)
      acc_n <= acc_n + 1;
    if (cmd_error === 1'b1)
      err_n <= err_n + 1;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count = bad_count + 1;
      $display("timeout reached");
      conclude();
    end
  end

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  function automatic logic [15:0] crc_b(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++)
      c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
    return c;
  endfunction

  // Wraps payload p in a frame; bad flips checksum bits
  task automatic mk(input logic [7:0] kind, input logic [7:0] bad);
    logic [15:0] c;
    logic [15:0] len;
    len = 16'(p.size());
    fr = {8'h5A, kind, len[7:0], len[15:8]};
    c = 16'h0000;
    foreach (fr[i]) c = crc_b(c, fr[i]);
    foreach (p[i]) c = crc_b(c, p[i]);
    c = c ^ {8'h00, bad};
    fr = {fr, c[7:0], c[15:8], p};
  endtask

  task automatic send(input logic [7:0] kind, input logic [7:0] tag, input logic [7:0] flg,
                      input logic [7:0] cnt, input int nargs, input logic [7:0] bad);
    int n;
    int a0;
    int e0;
    p = {tag, flg, 8'h00, cnt};
    for (int i = 0; i < 4 * nargs; i++)
      p.push_back(8'h30 + 8'(i));
    mk(kind, bad);
    a0 = acc_n;
    e0 = err_n;
    n = 0;
    @(posedge clk_sys);
    foreach (fr[i]) u_host.send_q.push_back(fr[i]);
    while (acc_n == a0 && err_n == e0 && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
    r = (acc_n != a0) ? 1 : ((err_n != e0) ? 2 : 0);
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_crc;
    string s;
    s = "123456789";
    bus(1'b1, 4'h7, 32'h00000100);
    bus(1'b0, 4'h7, 32'h00000000);
    chk("crc cleared", rd[15:0], 16'h0000);
    for (int i = 0; i < 9; i++)
      bus(1'b1, 4'h7, {24'h000000, s[i]});
    bus(1'b0, 4'h7, 32'h00000000);
    chk("crc of digits", rd[15:0], 16'h31C3);
    $display("test crc done");
  endtask

  task automatic t_rx;
    send(8'hA4, 8'h07, 8'hFF, 8'h02, 2, 8'h00);
    chk("verdict", r, 1);
    chk("tag", cmd_tag, 8'h07);
    chk("tally", cmd_argument_tally, 8'h02);
    chk("data phase", cmd_data_phase, 1'b1);
    send(8'hA4, 8'h03, 8'hFE, 8'h01, 1, 8'h00);
    chk("data phase", cmd_data_phase, 1'b0);
    bus(1'b0, 4'h2, 32'h00000000);
    chk("header", rd, 32'h0100FE03);
    bus(1'b0, 4'h3, 32'h00000000);
    chk("argument", rd, 32'h33323130);
    $display("test receive done");
  endtask

  task automatic t_err;
    bus(1'b1, 4'h1, 32'h0000000F);
    send(8'hA4, 8'h07, 8'h00, 8'h02, 2, 8'h01);
    chk("bad crc verdict", r, 2);
    bus(1'b0, 4'h1, 32'h00000000);
    chk("crc flag", rd[0], 1'b1);
    send(8'hA4, 8'h07, 8'h00, 8'h08, 8, 8'h00);
    chk("count verdict", r, 2);
    send(8'hA4, 8'h07, 8'h00, 8'h03, 2, 8'h00);
    chk("mismatch verdict", r, 2);
    bus(1'b1, 4'h1, 32'h0000000F);
    send(8'hA5, 8'h55, 8'h00, 8'h00, 1, 8'h00);
    chk("data verdict", r, 0);
    bus(1'b0, 4'h1, 32'h00000000);
    chk("status", rd[3:0], 4'h8);
    $display("test errors done");
  endtask

  task automatic t_tags;
    for (int t = 0; t <= 20; t++) begin
      send(8'hA4, 8'(t), 8'h00, 8'h00, 0, 8'h00);
      chk("tag verdict", r, (t >= 1 && t <= 18 && t != 8 && t != 17) ? 1 : 2);
    end
    bus(1'b1, 4'h0, 32'h00000003);
    send(8'hA4, 8'h11, 8'h00, 8'h00, 0, 8'h00);
    chk("tag 11 enabled", r, 1);
    bus(1'b1, 4'h0, 32'h00000001);
    $display("test tags done");
  endtask

  task automatic wait_tx(input int n);
    int k;
    k = 0;
    while (u_host.got_q.size() < n && k < 3000) begin
      @(posedge clk_sys);
      k++;
    end
  endtask

  task automatic t_tx;
    logic [15:0] c;
    slow <= 1'b1;
    u_host.got_q.delete();
    bus(1'b1, 4'h4, 32'h01AB01A3);
    bus(1'b1, 4'h5, 32'h44332211);
    bus(1'b1, 4'h6, 32'h00000001);
    p = {8'hA3, 8'h01, 8'h00, 8'h01, 8'h11, 8'h22, 8'h33, 8'h44};
    mk(8'hA4, 8'h00);
    wait_tx(14);
    foreach (fr[i]) chk("reply byte", u_host.got_q[i], fr[i]);
    slow <= 1'b0;
    u_host.got_q.delete();
    bus(1'b1, 4'h4, 32'h090000A0);
    bus(1'b0, 4'h4, 32'h00000000);
    chk("reply header", rd, 32'h070000A0);
    bus(1'b1, 4'h6, 32'h00000001);
    wait_tx(38);
    chk("reply length", u_host.got_q[2], 8'h20);
    chk("reply count", u_host.got_q[9], 8'h07);
    c = 16'h0000;
    foreach (u_host.got_q[i]) if (i < 4 || i > 5) c = crc_b(c, u_host.got_q[i]);
    chk("reply crc", c, {u_host.got_q[5], u_host.got_q[4]});
    $display("test transmit done");
  endtask

  initial begin
    bad_count = 0;
    checks_done = 0;
    cyc = 0;
    acc_n = 0;
    err_n = 0;
    nrst = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h00000000;
    link_enable_pin = 1'b1;
    slow = 1'b0;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (8) @(posedge clk_sys);
    t_crc();
    t_rx();
    t_err();
    t_tags();
    t_tx();
    conclude();
  end
endmodule
